// [core/msc_speed_cmd.sv]
// Speed command selector with APB register slave
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none

// How it works
// R1: one of four sources feeds the duty command, picked by source select.
// R2: select 00b takes duty from the digitized analog level.
// R3: analog level at or below standby threshold gives zero duty.
// R4: between standby and full scale duty rises linearly with level.
// R5: analog level at or above full scale saturates duty at 100%.
// R6: select 01b takes duty from the pin's pulse duty cycle.
// R7: duty is proportional to measured high time over period, up to 100%.
// R8: pin low longer than the PWM standby timeout forces zero duty.
// R9: rate band select sets the frequency measurement window; host stays in band.
// R10: output switch rate setting never touches input rate measurement.
// R11: duty or speed reference under 1% clamps speed reference to zero.
// R12: top speed limit of zero forces speed reference to zero.
// R13: select 10b takes duty from the host duty register; pin only idles.
// R14: select 11b duty is input frequency over maximum frequency, saturating.
// R15: duty is an unsigned fraction; analog arrives as a converter sample.
// R16: duty and speed reference update once per control-loop tick.
module msc_speed_cmd
  import msc_pkg::*;
#(
  parameter int unsigned WIN_CYC_B0 = 1000000,
  parameter int unsigned WIN_CYC_B1 = 100000,
  parameter int unsigned WIN_CYC_B2 = 10000,
  parameter int unsigned WIN_CYC_B3 = 1000
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // Rate command pin, asynchronous
  input  wire logic          speed_pin,
  // Converter sample, same clock
  input  wire logic          adc_valid,
  input  wire logic [AW-1:0] adc_sample,
  // Control loop
  input  wire logic          loop_tick,
  output logic [DW-1:0]      duty_cmd,
  output logic [DW-1:0]      speed_ref,
  output logic               ref_update,
  output logic               pin_idle
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == ADDR_CTRL) || (a == ADDR_HOST_DUTY) ||
              (a == ADDR_ANA_CFG) || (a == ADDR_MAX_FREQ) ||
              (a == ADDR_MAX_SPEED) || (a == ADDR_STATUS) ||
              (a == ADDR_SPEED_REF);
  endfunction

  function automatic logic [CW-1:0] win_len(input logic [1:0] band);
    case (band)
      2'h0:    win_len = CW'(WIN_CYC_B0);
      2'h1:    win_len = CW'(WIN_CYC_B1);
      2'h2:    win_len = CW'(WIN_CYC_B2);
      default: win_len = CW'(WIN_CYC_B3);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [5:0]    ctrl_ff,      nxt_ctrl;
  logic [DW-1:0] host_duty_ff, nxt_host_duty;
  logic [AW-1:0] sb_thr_ff,    nxt_sb_thr;
  logic [AW-1:0] fs_volt_ff,   nxt_fs_volt;
  logic [CW-1:0] max_freq_ff,  nxt_max_freq;
  logic [DW-1:0] max_speed_ff, nxt_max_speed;
  logic [31:0]   prdata_ff,    nxt_prdata;
  logic          pslverr_ff,   nxt_pslverr;
  logic [AW-1:0] adc_ff,       nxt_adc;
  logic          setup_ph;
  logic          wr_acc;
  msc_src_t      src;
  logic [1:0]    band;

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite & addr_ok(paddr);
  assign pready   = 1'b1;
  assign prdata   = prdata_ff;
  assign pslverr  = pslverr_ff;
  assign src      = msc_src_t'(ctrl_ff[SRC_LSB +: 2]);   // see R1
  assign band     = ctrl_ff[BAND_LSB +: 2];              // see R9

  // Write decode, read capture in setup, sample capture
  always_comb begin
    nxt_ctrl      = ctrl_ff;
    nxt_host_duty = host_duty_ff;
    nxt_sb_thr    = sb_thr_ff;
    nxt_fs_volt   = fs_volt_ff;
    nxt_max_freq  = max_freq_ff;
    nxt_max_speed = max_speed_ff;
    nxt_prdata    = prdata_ff;
    nxt_pslverr   = pslverr_ff;
    nxt_adc       = adc_valid ? adc_sample : adc_ff;    // see R15
    if (wr_acc) begin
      case (paddr)
        ADDR_CTRL:      nxt_ctrl      = pwdata[5:0];     // see R10
        ADDR_HOST_DUTY: nxt_host_duty = pwdata[DW-1:0];
        ADDR_ANA_CFG: begin
          nxt_sb_thr  = pwdata[SB_LSB +: AW];
          nxt_fs_volt = pwdata[FS_LSB +: AW];
        end
        ADDR_MAX_FREQ:  nxt_max_freq  = pwdata[CW-1:0];
        ADDR_MAX_SPEED: nxt_max_speed = pwdata[DW-1:0];
        default: ;
      endcase
    end
    if (setup_ph) begin
      nxt_pslverr = ~addr_ok(paddr);
      case (paddr)
        ADDR_CTRL:      nxt_prdata = {26'h0, ctrl_ff};
        ADDR_HOST_DUTY: nxt_prdata = {16'h0, host_duty_ff};
        ADDR_ANA_CFG:   nxt_prdata = {4'h0, fs_volt_ff, 4'h0, sb_thr_ff};
        ADDR_MAX_FREQ:  nxt_prdata = {8'h0, max_freq_ff};
        ADDR_MAX_SPEED: nxt_prdata = {16'h0, max_speed_ff};
        ADDR_STATUS:    nxt_prdata = {15'h0, pin_idle, duty_cmd};
        ADDR_SPEED_REF: nxt_prdata = {16'h0, speed_ref};
        default:        nxt_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff      <= CTRL_RST;
      host_duty_ff <= HOST_DUTY_RST;
      sb_thr_ff    <= SB_THR_RST;
      fs_volt_ff   <= FS_VOLT_RST;
      max_freq_ff  <= MAX_FREQ_RST;
      max_speed_ff <= MAX_SPEED_RST;
      prdata_ff    <= 32'h0;
      pslverr_ff   <= 1'b0;
      adc_ff       <= 12'h000;
    end else begin
      ctrl_ff      <= nxt_ctrl;
      host_duty_ff <= nxt_host_duty;
      sb_thr_ff    <= nxt_sb_thr;
      fs_volt_ff   <= nxt_fs_volt;
      max_freq_ff  <= nxt_max_freq;
      max_speed_ff <= nxt_max_speed;
      prdata_ff    <= nxt_prdata;
      pslverr_ff   <= nxt_pslverr;
      adc_ff       <= nxt_adc;
    end
  end

  // ----------------------------------------------------------------
  // Pin measurement
  // ----------------------------------------------------------------
  logic          pin_s1_ff, pin_s2_ff, pin_d_ff;
  logic [CW-1:0] run_ff, nxt_run, hi_ff, nxt_hi, per_ff, nxt_per;
  logic [CW-1:0] hi_lat_ff, nxt_hi_lat, per_lat_ff, nxt_per_lat;
  logic [CW-1:0] win_ff, nxt_win, edg_ff, nxt_edg, edg_lat_ff, nxt_edg_lat;
  logic          rise, run_out;

  assign rise     = pin_s2_ff & ~pin_d_ff;
  assign run_out  = (run_ff >= PWM_SB_CYC);
  assign pin_idle = run_out & ~pin_d_ff;                 // see R13

  // Level run, high time, period and windowed edge count
  always_comb begin
    nxt_run     = (pin_s2_ff != pin_d_ff) ? '0 :
                  (run_out ? run_ff : run_ff + 1'b1);    // see R8
    nxt_hi      = hi_ff + CW'(pin_s2_ff);
    nxt_per     = (&per_ff) ? per_ff : per_ff + 1'b1;
    nxt_hi_lat  = hi_lat_ff;
    nxt_per_lat = per_lat_ff;
    if (rise) begin
      nxt_hi_lat  = hi_ff;                               // see R7
      nxt_per_lat = per_ff;
      nxt_hi      = CW'(1);
      nxt_per     = CW'(1);
    end
    nxt_edg     = edg_ff + CW'(rise);
    nxt_win     = win_ff + 1'b1;
    nxt_edg_lat = edg_lat_ff;
    if (win_ff >= win_len(band) - 1'b1) begin            // see R9
      nxt_edg_lat = edg_ff;
      nxt_edg     = CW'(rise);
      nxt_win     = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff  <= 1'b0;
      pin_s2_ff  <= 1'b0;
      pin_d_ff   <= 1'b0;
      run_ff     <= '0;
      hi_ff      <= '0;
      per_ff     <= '0;
      hi_lat_ff  <= '0;
      per_lat_ff <= '0;
      win_ff     <= '0;
      edg_ff     <= '0;
      edg_lat_ff <= '0;
    end else begin
      pin_s1_ff  <= speed_pin;
      pin_s2_ff  <= pin_s1_ff;
      pin_d_ff   <= pin_s2_ff;
      run_ff     <= nxt_run;
      hi_ff      <= nxt_hi;
      per_ff     <= nxt_per;
      hi_lat_ff  <= nxt_hi_lat;
      per_lat_ff <= nxt_per_lat;
      win_ff     <= nxt_win;
      edg_ff     <= nxt_edg;
      edg_lat_ff <= nxt_edg_lat;
    end
  end

  // ----------------------------------------------------------------
  // Per-tick selection, divider and speed reference
  // ----------------------------------------------------------------
  msc_state_t    st_ff, nxt_st;
  logic [CW:0]   rem_ff, nxt_rem;
  logic [CW-1:0] den_ff, nxt_den;
  logic [DW-1:0] q_ff, nxt_q, duty_ff, nxt_duty, ref_ff, nxt_ref;
  logic [4:0]    step_ff, nxt_step;
  logic          upd_ff, nxt_upd;
  logic [31:0]   prod;
  logic [DW-1:0] scaled;

  assign prod     = q_ff * max_speed_ff;
  assign scaled   = prod[31:DW];
  assign duty_cmd = duty_ff;
  assign speed_ref = ref_ff;
  assign ref_update = upd_ff;

  // Tick-driven state machine
  always_comb begin
    nxt_st   = st_ff;
    nxt_rem  = rem_ff;
    nxt_den  = den_ff;
    nxt_q    = q_ff;
    nxt_duty = duty_ff;
    nxt_ref  = ref_ff;
    nxt_step = step_ff;
    nxt_upd  = 1'b0;
    case (st_ff)
      ST_IDLE: begin
        if (loop_tick) begin                             // see R16
          nxt_st   = ST_OUT;
          nxt_step = '0;
          nxt_q    = DUTY_ZERO;
          case (src)
            SRC_ANALOG: begin
              if (adc_ff <= sb_thr_ff) nxt_q = DUTY_ZERO;  // see R3
              else if (adc_ff >= fs_volt_ff) nxt_q = DUTY_FULL; // see R5
              else begin                                 // see R2, R4
                nxt_rem = (CW+1)'(adc_ff - sb_thr_ff);
                nxt_den = CW'(fs_volt_ff - sb_thr_ff);
                nxt_st  = ST_DIV;
              end
            end
            SRC_PWM: begin                               // see R6
              if (run_out) nxt_q = pin_d_ff ? DUTY_FULL : DUTY_ZERO; // see R8
              else if (per_lat_ff == '0) nxt_q = DUTY_ZERO;
              else if (hi_lat_ff >= per_lat_ff) nxt_q = DUTY_FULL;
              else begin                                 // see R7
                nxt_rem = {1'b0, hi_lat_ff};
                nxt_den = per_lat_ff;
                nxt_st  = ST_DIV;
              end
            end
            SRC_HOST: nxt_q = host_duty_ff;              // see R13
            default: begin                               // see R14
              if (run_out && !pin_d_ff) nxt_q = DUTY_ZERO;
              else if (edg_lat_ff >= max_freq_ff) nxt_q = DUTY_FULL;
              else begin
                nxt_rem = {1'b0, edg_lat_ff};
                nxt_den = max_freq_ff;
                nxt_st  = ST_DIV;
              end
            end
          endcase
        end
      end
      ST_DIV: begin
        // Restoring division, one quotient bit per cycle
        if ({rem_ff[CW-1:0], 1'b0} >= {1'b0, den_ff}) begin
          nxt_rem = {rem_ff[CW-1:0], 1'b0} - {1'b0, den_ff};
          nxt_q   = {q_ff[DW-2:0], 1'b1};
        end else begin
          nxt_rem = {rem_ff[CW-1:0], 1'b0};
          nxt_q   = {q_ff[DW-2:0], 1'b0};
        end
        nxt_step = step_ff + 1'b1;
        if (step_ff == DIV_LAST) nxt_st = ST_OUT;
      end
      ST_OUT: begin
        nxt_duty = q_ff;
        nxt_upd  = 1'b1;
        if (q_ff < ONE_PCT || max_speed_ff == DUTY_ZERO ||
            scaled < ONE_PCT)                            // see R11, R12
          nxt_ref = DUTY_ZERO;
        else
          nxt_ref = scaled;
        nxt_st = ST_IDLE;
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff   <= ST_IDLE;
      rem_ff  <= '0;
      den_ff  <= '0;
      q_ff    <= DUTY_ZERO;
      duty_ff <= DUTY_ZERO;
      ref_ff  <= DUTY_ZERO;
      step_ff <= '0;
      upd_ff  <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      rem_ff  <= nxt_rem;
      den_ff  <= nxt_den;
      q_ff    <= nxt_q;
      duty_ff <= nxt_duty;
      ref_ff  <= nxt_ref;
      step_ff <= nxt_step;
      upd_ff  <= nxt_upd;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tick_idle;
    (st_ff == ST_IDLE) && loop_tick;
  endsequence
  sequence s_div_run;
    (st_ff == ST_DIV) [*8] ##1 (st_ff == ST_DIV) [*8] ##1 (st_ff == ST_OUT);
  endsequence

  a_tick_starts: assert property ( // see R16
    s_tick_idle |=> st_ff != ST_IDLE ##1 1'b1)
    else $error("tick did not start an update");
  a_div_length: assert property ( // see R16
    s_tick_idle ##1 (st_ff == ST_DIV) |-> s_div_run)
    else $error("division not 16 cycles");
  a_analog_low: assert property ( // see R3
    s_tick_idle ##0 (src == SRC_ANALOG) && (adc_ff <= sb_thr_ff)
    |-> ##2 duty_cmd == DUTY_ZERO)
    else $error("analog standby duty not zero");
  a_analog_sat: assert property ( // see R5
    s_tick_idle ##0 (src == SRC_ANALOG) && (adc_ff > sb_thr_ff) &&
    (adc_ff >= fs_volt_ff) |-> ##2 duty_cmd == DUTY_FULL)
    else $error("analog not saturated");
  a_pwm_standby: assert property ( // see R8
    s_tick_idle ##0 (src == SRC_PWM) && run_out && !pin_d_ff
    |-> ##2 duty_cmd == DUTY_ZERO && ref_update)
    else $error("pwm standby duty not zero");
  a_host_duty: assert property ( // see R13
    s_tick_idle ##0 (src == SRC_HOST)
    |-> ##2 duty_cmd == $past(host_duty_ff, 2))
    else $error("host duty not taken");
  a_ref_low: assert property ( // see R11
    (st_ff == ST_OUT) && (q_ff < ONE_PCT) |=> speed_ref == DUTY_ZERO)
    else $error("ref not clamped under one percent");
  a_ref_maxzero: assert property ( // see R12
    (st_ff == ST_OUT) && (max_speed_ff == DUTY_ZERO)
    |=> speed_ref == DUTY_ZERO && ref_update)
    else $error("ref not zero at zero limit");
  a_freq_full: assert property ( // see R14
    s_tick_idle ##0 (src == SRC_FREQ) && !(run_out && !pin_d_ff) &&
    (edg_lat_ff >= max_freq_ff) |-> ##2 duty_cmd == DUTY_FULL)
    else $error("freq not saturated");
  a_band_window: assert property ( // see R9
    win_ff < win_len(band) || $changed(band))
    else $error("window past band length");
  a_apb_unmapped: assert property ( // see the address map
    setup_ph && !addr_ok(paddr) |=> pslverr && prdata == 32'h0)
    else $error("unmapped not flagged");

endmodule

`default_nettype wire

// [core/msc_pkg.sv]
// Constants and types of the speed command selector
package msc_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_HOST_DUTY = 12'h004;
  localparam logic [11:0] ADDR_ANA_CFG   = 12'h008;
  localparam logic [11:0] ADDR_MAX_FREQ  = 12'h00c;
  localparam logic [11:0] ADDR_MAX_SPEED = 12'h010;
  localparam logic [11:0] ADDR_STATUS    = 12'h014;
  localparam logic [11:0] ADDR_SPEED_REF = 12'h018;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SRC_LSB  = 0;
  localparam int BAND_LSB = 2;
  localparam int SWR_LSB  = 4;
  localparam int SB_LSB   = 0;
  localparam int FS_LSB   = 16;
  localparam int IDLE_BIT = 16;
  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int CW = 24;  // Counter and divider width
  localparam int DW = 16;  // Duty and speed width
  localparam int AW = 12;  // Converter sample width
  localparam logic [5:0]    CTRL_RST      = 6'h00;
  localparam logic [DW-1:0] HOST_DUTY_RST = 16'h0000;
  localparam logic [AW-1:0] SB_THR_RST    = 12'h0a0;
  localparam logic [AW-1:0] FS_VOLT_RST   = 12'hf00;
  localparam logic [CW-1:0] MAX_FREQ_RST  = 24'h0003e8;
  localparam logic [DW-1:0] MAX_SPEED_RST = 16'h0000;
  // ----------------------------------------------------------------
  // Duty scale: 16'hffff is full scale
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] DUTY_FULL = 16'hffff;
  localparam logic [DW-1:0] DUTY_ZERO = 16'h0000;
  localparam logic [DW-1:0] ONE_PCT   = 16'h0290;  // Lowest duty >= 1%
  localparam logic [4:0]    DIV_LAST  = 5'h0f;     // 16 quotient bits
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int PWM_SB_TIMEOUT_NS = 20000;
  localparam logic [CW-1:0] PWM_SB_CYC =
    CW'((PWM_SB_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ----------------------------------------------------------------
  // Sources and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_ANALOG = 2'h0,
    SRC_PWM    = 2'h1,
    SRC_HOST   = 2'h2,
    SRC_FREQ   = 2'h3
  } msc_src_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_DIV  = 3'h2,
    ST_OUT  = 3'h4
  } msc_state_t;
endpackage

// [sim/msc_host_pin.sv]
// Host controller model driving the rate command pin
`timescale 1ns/10ps
`default_nettype none

module msc_host_pin (
  // Clock
  input  wire logic        pclk,
  // Waveform control from the bench
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] hi_cyc,
  input  wire logic [15:0] per_cyc,
  // Rate command pin
  output logic             speed_pin
);
  logic [15:0] cnt_ff = 16'h0000;

  // ------------------------------------------------------------
  // Pulse generator: 0 low, 1 high, 2 pulse train
  // ------------------------------------------------------------
  // Period is kept inside the chosen band by the bench
  always_ff @(posedge pclk) begin
    if (cnt_ff + 16'h0001 >= per_cyc) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
    speed_pin <= (mode == 2'h1) | ((mode == 2'h2) & (cnt_ff < hi_cyc));
  end
endmodule

`default_nettype wire

// [sim/tb_motor_speed_command_select.sv]
// Self-checking bench for the speed command selector
`timescale 1ns/10ps
`default_nettype none

module tb_motor_speed_command_select;
  import msc_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic          pclk = 1'b0;
  logic          presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata;
  logic          speed_pin, adc_valid, loop_tick, ref_update, pin_idle;
  logic [AW-1:0] adc_sample;
  logic [DW-1:0] duty_cmd, speed_ref;
  logic [1:0]    pmode;
  logic [15:0]   phi, pper;
  int            fail_count = 0;
  int            comparisons = 0;
  logic [31:0]   rst_tab [7] = '{32'h0, 32'h0, 32'h0f0000a0, 32'h3e8,
                                 32'h0, 32'h0, 32'h0};
  logic [11:0]   ana_tab [4] = '{12'h09f, 12'h0a0, 12'hf00, 12'hfff};
  logic [5:0]    frq_ctl [5] = '{6'h03, 6'h0f, 6'h3f, 6'h17, 6'h2b};
  logic [15:0]   frq_exp [5] = '{16'hffff, 16'haaaa, 16'haaaa, 16'hffff,
                                 16'hffff};
  logic [15:0]   frq_tol [5] = '{16'h0000, 16'h1a00, 16'h1a00, 16'h0000,
                                 16'h0000};

  always #5 pclk = ~pclk;

  msc_speed_cmd #(.WIN_CYC_B0(200), .WIN_CYC_B1(400), .WIN_CYC_B2(800),
                  .WIN_CYC_B3(100)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .speed_pin(speed_pin),
    .adc_valid(adc_valid), .adc_sample(adc_sample), .loop_tick(loop_tick),
    .duty_cmd(duty_cmd), .speed_ref(speed_ref), .ref_update(ref_update),
    .pin_idle(pin_idle));

  msc_host_pin host_u (.pclk(pclk), .mode(pmode), .hi_cyc(phi),
                       .per_cyc(pper), .speed_pin(speed_pin));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic close_out();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Wait limit ran out
  task automatic hang();
    fail_count++;
    close_out();
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rv,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) hang();
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rv;
    logic        e;
    apb(1'b1, a, d, rv, e);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] rv;
    logic        e;
    apb(1'b0, a, 32'h0, rv, e);
    check(rv, x);
  endtask

  // Tick after a safe gap, count cycles to the update pulse
  task automatic tick(output int n);
    repeat (20) @(posedge pclk);
    loop_tick <= 1'b1;
    @(posedge pclk);
    loop_tick <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (ref_update !== 1'b1 && n < 60);
    if (ref_update !== 1'b1) hang();
  endtask

  task automatic adc(input logic [11:0] s);
    @(posedge pclk);
    adc_valid <= 1'b1;
    adc_sample <= s;
    @(posedge pclk);
    adc_valid <= 1'b0;
  endtask

  task automatic pin(input logic [1:0] m, input logic [15:0] h,
                     input logic [15:0] p, input int w);
    @(posedge pclk);
    pmode <= m;
    phi <= h;
    pper <= p;
    repeat (w) @(posedge pclk);
  endtask

  function automatic logic [15:0] ratio(logic [15:0] a, logic [15:0] b);
    return 16'((32'(a) * 32'hffff) / 32'(b));
  endfunction

  function automatic logic near(logic [15:0] a, logic [15:0] b,
                                logic [15:0] t);
    return ((a > b) ? a - b : b - a) <= t;
  endfunction

  // Expected reference with the 1% and zero-limit clamps
  function automatic logic [15:0] exp_ref(logic [15:0] d, logic [15:0] m);
    logic [31:0] p;
    p = 32'(d) * 32'(m);
    if (d < ONE_PCT || m == 16'h0 || p[31:16] < ONE_PCT) return 16'h0;
    return p[31:16];
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] rv;
    logic        e;
    logic [15:0] d, m, x, exp_d;
    logic [11:0] s;
    int          n;
    {presetn, psel, penable, pwrite, adc_valid, loop_tick} = 6'h00;
    {paddr, pwdata, adc_sample} = 56'h0;
    {pmode, phi, pper} = {2'h1, 16'h0, 16'h0064};
    void'($urandom(16373));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    // Reset values, unmapped and read-only places
    for (int i = 0; i < 7; i++) rdchk(12'(i * 4), rst_tab[i]);
    apb(1'b0, 12'h01c, 32'h0, rv, e);
    check({31'h0, e}, 32'h1);
    check(rv, 32'h0);
    wr(ADDR_STATUS, 32'hffffffff);
    rdchk(ADDR_STATUS, 32'h0);
    // Host register source, zero top speed first
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_HOST_DUTY, 32'h8000);
    tick(n);
    check(duty_cmd, 32'h8000);
    check(speed_ref, 32'h0);
    exp_d = 16'h8000;
    m = 16'($urandom) | 16'h0100;
    wr(ADDR_MAX_SPEED, {16'h0, m});
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? ONE_PCT - 16'h0001 : (i == 1) ? ONE_PCT :
          (i == 2) ? DUTY_FULL : 16'($urandom);
      wr(ADDR_HOST_DUTY, {16'h0, d});
      check(duty_cmd, exp_d);
      tick(n);
      exp_d = d;
      check(n, 1);
      check(duty_cmd, d);
      check(speed_ref, exp_ref(d, m));
      rdchk(ADDR_SPEED_REF, {16'h0, exp_ref(d, m)});
      rdchk(ADDR_STATUS, {16'h0, d});
    end
    // Analog source: boundaries exact, mid samples near the line
    wr(ADDR_MAX_SPEED, 32'hffff);
    wr(ADDR_CTRL, 32'h0);
    for (int i = 0; i < 6; i++) begin
      s = (i < 4) ? ana_tab[i] : 12'h0a1 + 12'($urandom % 32'he5e);
      x = (s <= SB_THR_RST) ? 16'h0 : (s >= FS_VOLT_RST) ? DUTY_FULL :
          ratio(16'(s - SB_THR_RST), 16'(FS_VOLT_RST - SB_THR_RST));
      adc(s);
      tick(n);
      check({31'h0, near(duty_cmd, x, (i < 4) ? 16'h0 : 16'h0040)}, 1);
    end
    wr(ADDR_CTRL, 32'h2);
    tick(n);
    check(duty_cmd, exp_d);
    // Pulse duty source
    wr(ADDR_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      d = 16'(1 + $urandom % 99);
      pin(2'h2, d, 16'h0064, 400);
      tick(n);
      check({31'h0, near(duty_cmd, ratio(d, 16'h0064), 16'h0300)}, 1);
    end
    pin(2'h1, 16'h0, 16'h0064, 2100);
    tick(n);
    check(duty_cmd, 32'hffff);
    pin(2'h0, 16'h0, 16'h0064, 2100);
    check(pin_idle, 32'h1);
    tick(n);
    check(duty_cmd, 32'h0);
    check(speed_ref, 32'h0);
    rdchk(ADDR_STATUS, 32'h10000);
    // Frequency source across bands and output switch rate
    wr(ADDR_MAX_FREQ, 32'ha);
    pin(2'h2, 16'h0007, 16'h000f, 0);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CTRL, {26'h0, frq_ctl[i]});
      repeat (1700) @(posedge pclk);
      tick(n);
      check({31'h0, near(duty_cmd, frq_exp[i], frq_tol[i])}, 1);
    end
    // Mid-run reset returns outputs and registers to rest
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(duty_cmd, 32'h0);
    check(speed_ref, 32'h0);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_MAX_SPEED, 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
